//--- hdl/rtc_timer.sv
// reload timer with oscillator capture, ahb-lite register slave
// assumes ext_osc is the raw external oscillator, slower than hclk / 4
// assumes whole-word single transfers; hsize and haddr above bit 7 ignored
// assumes one slave, so hready is this block's own hreadyout
//
// What this block does
// - two count bytes, 16-bit or split mode
// - clocks: sysclk, sysclk/12, synced external/8
// - 16-bit overflow reloads both bytes, sets high flag
// - 16-bit overflow raises interrupt when enabled
// - low-byte roll also interrupts when low enable set
// - split bytes reload from own reload byte
// - split mode: run gates high byte only
// - per-byte fast select, else external select picks
// - split: each byte roll sets its flag
// - split: high roll interrupts, low too if enabled
// - flags only cleared by software writes
// - capture mode counts on sysclk or sysclk/12
// - capture copies counter to reload, sets high flag
// - capture on each falling edge of external/8
// - capture enable bit selects capture mode
// - low flag set on every low-byte roll
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module rtc_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic ext_osc,
  output logic timer_irq
);

  // bus slave
  rtc_pkg::rtc_bus_st_t bus_q;
  logic wr_pend_q;
  logic [7:0] addr_q;
  logic [31:0] rdata_q;
  logic ready_q;
  logic [1:0] resp_q;
  logic irq_q;

  wire logic addr_take = hsel && hready && (htrans == rtc_pkg::HTRANS_NONSEQ);
  wire logic rd_take = addr_take && !hwrite;
  wire logic wr_take = addr_take && hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_q <= rtc_pkg::BUS_IDLE;
    end else begin
      case (bus_q)
        rtc_pkg::BUS_IDLE: bus_q <= rd_take ? rtc_pkg::BUS_READ_WAIT : rtc_pkg::BUS_IDLE;
        rtc_pkg::BUS_READ_WAIT: bus_q <= rtc_pkg::BUS_IDLE;
        default: bus_q <= rtc_pkg::BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
      ready_q <= 1'b1;
      resp_q <= rtc_pkg::HRESP_OKAY;
    end else begin
      wr_pend_q <= wr_take;
      if (addr_take) begin
        addr_q <= haddr[7:0];
      end
      ready_q <= !rd_take;
      // slave never signals an error
      resp_q <= rtc_pkg::HRESP_OKAY;
    end
  end

  // write strobes in the data phase, word addresses only
  wire logic wr_now = wr_pend_q;
  wire logic [7:0] wbyte = hwdata[7:0];
  wire logic wr_ctrl = wr_now && (addr_q == rtc_pkg::OFS_CTRL);
  wire logic wr_clk = wr_now && (addr_q == rtc_pkg::OFS_CLK);
  wire logic wr_rld_lo = wr_now && (addr_q == rtc_pkg::OFS_RLD_LO);
  wire logic wr_rld_hi = wr_now && (addr_q == rtc_pkg::OFS_RLD_HI);
  wire logic wr_cnt_lo = wr_now && (addr_q == rtc_pkg::OFS_CNT_LO);
  wire logic wr_cnt_hi = wr_now && (addr_q == rtc_pkg::OFS_CNT_HI);

  // registers
  rtc_pkg::rtc_ctrl_t ctrl_q;
  rtc_pkg::rtc_ctrl_t ctrl_d;
  rtc_pkg::rtc_clk_t clk_q;
  logic [7:0] rld_q [2];
  logic [7:0] rld_d [2];
  logic [7:0] cnt_q [2];
  logic [7:0] cnt_d [2];

  // clock sources
  logic [3:0] div12_q;
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic [2:0] ext_div_q;

  wire logic div12_tick = (div12_q == rtc_pkg::DIV12_LAST);
  // rising edge of the synchronised oscillator, seen once
  wire logic osc_rise = osc_s2_q && !osc_s3_q;
  // external/8 rises and falls, one hclk pulse per edge
  wire logic ext_rise = osc_rise && (ext_div_q == rtc_pkg::EXT_RISE_AT);
  wire logic ext_fall = osc_rise && (ext_div_q == rtc_pkg::EXT_FALL_AT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div12_q <= 4'h0;
    end else begin
      div12_q <= div12_tick ? 4'h0 : div12_q + 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= ext_osc;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_div_q <= 3'h0;
    end else if (osc_rise) begin
      ext_div_q <= ext_div_q + 3'h1;
    end
  end

  // per-byte tick: index 0 low byte, index 1 high byte
  logic [1:0] fast_sel;
  logic [1:0] byte_tick;
  assign fast_sel = {clk_q.high_fast_clock_select, clk_q.low_fast_clock_select};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tick
      assign byte_tick[gi] = fast_sel[gi] ? 1'b1 :
                             (ctrl_q.ext_clock_select ? ext_rise : div12_tick);
    end
  endgenerate

  // capture mode ignores the external choice: it is the measured clock
  wire logic cap_tick = clk_q.low_fast_clock_select ? 1'b1 : div12_tick;

  // counting
  wire logic cap_mode = ctrl_q.capture_enable;
  wire logic split = ctrl_q.split_select && !cap_mode;
  wire logic run = ctrl_q.high_run_control;
  wire logic lo_full = (cnt_q[0] == rtc_pkg::BYTE_MAX);
  wire logic hi_full = (cnt_q[1] == rtc_pkg::BYTE_MAX);

  // 16-bit mode and capture mode step both bytes together on the low clock
  wire logic wide_step = run && (cap_mode ? cap_tick : byte_tick[0]);
  // split low byte ignores run control
  wire logic lo_step = split ? byte_tick[0] : wide_step;
  wire logic hi_step_split = run && byte_tick[1];

  wire logic lo_roll = lo_step && lo_full;
  wire logic wide_roll = !split && wide_step && lo_full && hi_full;
  wire logic hi_roll_split = split && hi_step_split && hi_full;
  wire logic do_capture = cap_mode && ext_fall;

  wire logic lo_roll_evt = lo_roll;
  wire logic hi_roll_evt = (wide_roll && !cap_mode) || hi_roll_split;

  always_comb begin
    // low byte
    cnt_d[0] = cnt_q[0];
    if (wr_cnt_lo) begin
      cnt_d[0] = wbyte;
    end else if (lo_roll && split) begin
      cnt_d[0] = rld_q[0];
    end else if (wide_roll && !cap_mode) begin
      cnt_d[0] = rld_q[0];
    end else if (lo_step) begin
      cnt_d[0] = cnt_q[0] + 8'h01;
    end
    // high byte
    cnt_d[1] = cnt_q[1];
    if (wr_cnt_hi) begin
      cnt_d[1] = wbyte;
    end else if (split) begin
      if (hi_roll_split) begin
        cnt_d[1] = rld_q[1];
      end else if (hi_step_split) begin
        cnt_d[1] = cnt_q[1] + 8'h01;
      end
    end else if (wide_roll && !cap_mode) begin
      cnt_d[1] = rld_q[1];
    end else if (wide_step && lo_full) begin
      cnt_d[1] = cnt_q[1] + 8'h01;
    end
  end

  always_comb begin
    rld_d[0] = rld_q[0];
    rld_d[1] = rld_q[1];
    if (do_capture) begin
      rld_d[0] = cnt_q[0];
      rld_d[1] = cnt_q[1];
    end else begin
      if (wr_rld_lo) begin
        rld_d[0] = wbyte;
      end
      if (wr_rld_hi) begin
        rld_d[1] = wbyte;
      end
    end
  end

  // control write; hardware set of a flag wins over a software clear
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = rtc_pkg::rtc_ctrl_t'(wbyte);
      ctrl_d.unused = 1'b0;
    end
    if (hi_roll_evt || do_capture) begin
      ctrl_d.high_overflow_flag = 1'b1;
    end
    if (lo_roll_evt) begin
      ctrl_d.low_overflow_flag = 1'b1;
    end
  end

  // interrupt follows the flags, so it stays until software clears them
  wire logic irq_d = clk_q.timer_irq_enable &&
                     (ctrl_d.high_overflow_flag ||
                      (ctrl_d.low_byte_irq_enable && ctrl_d.low_overflow_flag));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= rtc_pkg::rtc_ctrl_t'(rtc_pkg::RST_BYTE);
      clk_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      irq_q <= irq_d;
      if (wr_clk) begin
        clk_q <= rtc_pkg::rtc_clk_t'(wbyte[2:0]);
      end
    end
  end

  generate
    for (gi = 0; gi < 2; gi++) begin : g_byte
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_q[gi] <= rtc_pkg::RST_BYTE;
          rld_q[gi] <= rtc_pkg::RST_BYTE;
        end else begin
          cnt_q[gi] <= cnt_d[gi];
          rld_q[gi] <= rld_d[gi];
        end
      end
    end
  endgenerate

  // read path
  logic [7:0] rd_byte;
  always_comb begin
    case (addr_q)
      rtc_pkg::OFS_CTRL: rd_byte = ctrl_q;
      rtc_pkg::OFS_CLK: rd_byte = {5'h00, clk_q};
      rtc_pkg::OFS_RLD_LO: rd_byte = rld_q[0];
      rtc_pkg::OFS_RLD_HI: rd_byte = rld_q[1];
      rtc_pkg::OFS_CNT_LO: rd_byte = cnt_q[0];
      rtc_pkg::OFS_CNT_HI: rd_byte = cnt_q[1];
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h00000000;
    end else if (bus_q == rtc_pkg::BUS_READ_WAIT) begin
      rdata_q <= {24'h000000, rd_byte};
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = ready_q;
  assign hresp = resp_q;
  assign timer_irq = irq_q;

endmodule : rtc_timer

//--- include/rtc_pkg.sv
// package for the reload timer with oscillator capture
// assumes an ahb-lite slave with 32-bit data, one register per word
package rtc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CLK = 8'h04;
  localparam logic [7:0] OFS_RLD_LO = 8'h08;
  localparam logic [7:0] OFS_RLD_HI = 8'h0C;
  localparam logic [7:0] OFS_CNT_LO = 8'h10;
  localparam logic [7:0] OFS_CNT_HI = 8'h14;
  // reset value and byte maximum
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  // timing
  localparam int unsigned SYSCLK_DIV = 12;
  localparam int unsigned EXT_DIV = 8;
  localparam logic [3:0] DIV12_LAST = 4'(SYSCLK_DIV - 1);
  localparam logic [2:0] EXT_RISE_AT = 3'(EXT_DIV / 2 - 1);
  localparam logic [2:0] EXT_FALL_AT = 3'(EXT_DIV - 1);
  // bus
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  // timer_control_reg layout, bit 7 down to bit 0
  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_byte_irq_enable;
    logic capture_enable;
    logic split_select;
    logic high_run_control;
    logic unused;
    logic ext_clock_select;
  } rtc_ctrl_t;

  // clock_control_reg layout, bits 2 down to 0
  typedef struct packed {
    logic timer_irq_enable;
    logic high_fast_clock_select;
    logic low_fast_clock_select;
  } rtc_clk_t;

  typedef enum logic {BUS_IDLE, BUS_READ_WAIT} rtc_bus_st_t;
endpackage : rtc_pkg

//--- sim/rtc_timer_asserts.sv
// checker: bus timing and interrupt relations at the timer ports
// assumes one clock hclk and the async active-low reset hresetn
`timescale 1ns/1ps
module rtc_timer_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic [1:0] hresp,
  input wire logic timer_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic take = hsel && hready && htrans == rtc_pkg::HTRANS_NONSEQ;
  logic wr_q;
  logic rd_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= take && hwrite;
      rd_q <= take && !hwrite;
    end
  end
  resp_okay_a: assert property (hresp == rtc_pkg::HRESP_OKAY)
    else $error("response not okay");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  wait_cause_a: assert property ($fell(hreadyout) |-> rd_q)
    else $error("wait without read");
  wait_short_a: assert property (!hreadyout |=> hreadyout)
    else $error("wait too long");
  data_upper_a: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  data_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  irq_clear_a: assert property ($fell(timer_irq) |-> $past(wr_q) || $past(wr_q, 2))
    else $error("interrupt dropped without write");
endmodule : rtc_timer_asserts

bind rtc_timer rtc_timer_asserts u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .timer_irq);

//--- sim/tb_rtc_timer.sv
// testbench: register bus scenarios for the reload timer
// assumes rtc_timer is the only bus slave, hclk at 125 MHz
`timescale 1ns/1ps
module tb_rtc_timer;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ext_osc = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hrdata;
  logic [31:0] v;
  logic [15:0] w;
  logic [15:0] u;
  logic [1:0] hresp;
  logic hreadyout;
  logic timer_irq;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  always #4 hclk = ~hclk;
  int osc_cnt = 0;
  // oscillator with a period of 10 hclk, stepped at the rising edge
  always @(posedge hclk) begin
    if (osc_cnt == 4) begin
      osc_cnt <= 0;
      ext_osc <= ~ext_osc;
    end else begin
      osc_cnt <= osc_cnt + 1;
    end
  end
  rtc_timer uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_osc, .timer_irq);
  task give_verdict;
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: %h vs %h", $time, g, e);
    end
  endtask : chk
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= rtc_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge hclk iff hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk iff hreadyout);
    v = hrdata;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(v, e);
  endtask : rd
  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  task irq(input logic e);
    @(negedge hclk);
    chk({31'h0, timer_irq}, {31'h0, e});
    @(posedge hclk);
  endtask : irq
  task t_reset;
    for (int a = 0; a < 28; a += 4) rd(8'(a), 32'h0);
    wr(8'h18, 32'hFF);
    rd(8'h18, 32'h0);
    wr(rtc_pkg::OFS_CTRL, 32'h02);
    rd(rtc_pkg::OFS_CTRL, 32'h0);
  endtask : t_reset
  task t_wide;
    wr(rtc_pkg::OFS_CLK, 32'h07);
    wr(rtc_pkg::OFS_RLD_LO, 32'h34);
    wr(rtc_pkg::OFS_RLD_HI, 32'h12);
    wr(rtc_pkg::OFS_CNT_LO, 32'hF0);
    wr(rtc_pkg::OFS_CNT_HI, 32'hFF);
    wr(rtc_pkg::OFS_CTRL, 32'h04);
    cyc(40);
    rd(rtc_pkg::OFS_CTRL, 32'hC4);
    irq(1'b1);
    wr(rtc_pkg::OFS_CTRL, 32'h00);
    rd(rtc_pkg::OFS_CNT_HI, 32'h12);
    irq(1'b0);
    wr(rtc_pkg::OFS_CNT_HI, 32'h00);
    wr(rtc_pkg::OFS_CNT_LO, 32'hF8);
    wr(rtc_pkg::OFS_CTRL, 32'h24);
    cyc(20);
    rd(rtc_pkg::OFS_CTRL, 32'h64);
    irq(1'b1);
  endtask : t_wide
  task t_split;
    wr(rtc_pkg::OFS_CTRL, 32'h00);
    wr(rtc_pkg::OFS_CLK, 32'h05);
    wr(rtc_pkg::OFS_CNT_HI, 32'h77);
    wr(rtc_pkg::OFS_RLD_LO, 32'hF0);
    wr(rtc_pkg::OFS_CNT_LO, 32'hFE);
    wr(rtc_pkg::OFS_CTRL, 32'h08);
    cyc(30);
    rd(rtc_pkg::OFS_CTRL, 32'h48);
    rd(rtc_pkg::OFS_CNT_HI, 32'h77);
    irq(1'b0);
    bus(1'b0, rtc_pkg::OFS_CNT_LO, 32'h0);
    chk({31'h0, v[7:4] == 4'hF}, 32'h1);
    wr(rtc_pkg::OFS_CTRL, 32'h28);
    cyc(20);
    irq(1'b1);
    wr(rtc_pkg::OFS_CLK, 32'h07);
    wr(rtc_pkg::OFS_CNT_HI, 32'hFF);
    wr(rtc_pkg::OFS_CTRL, 32'h0C);
    cyc(3);
    bus(1'b0, rtc_pkg::OFS_CTRL, 32'h0);
    chk(v & 32'h80, 32'h80);
    irq(1'b1);
  endtask : t_split
  task t_rate(input logic [31:0] c, input int n, input int lo, input int hi, input int hlo,
    input int hhi);
    wr(rtc_pkg::OFS_CTRL, 32'h00);
    wr(rtc_pkg::OFS_CNT_LO, 32'h00);
    wr(rtc_pkg::OFS_CNT_HI, 32'h00);
    wr(rtc_pkg::OFS_CLK, 32'h00);
    wr(rtc_pkg::OFS_CTRL, c);
    cyc(n);
    bus(1'b0, rtc_pkg::OFS_CNT_LO, 32'h0);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
    bus(1'b0, rtc_pkg::OFS_CNT_HI, 32'h0);
    chk({31'h0, v >= hlo && v <= hhi}, 32'h1);
  endtask : t_rate
  task grab;
    int n;
    n = 0;
    v = 32'h0;
    while (v[7] !== 1'b1 && n < 100) begin
      bus(1'b0, rtc_pkg::OFS_CTRL, 32'h0);
      n++;
    end
    chk({31'h0, v[7]}, 32'h1);
    bus(1'b0, rtc_pkg::OFS_RLD_HI, 32'h0);
    w[15:8] = v[7:0];
    bus(1'b0, rtc_pkg::OFS_RLD_LO, 32'h0);
    w[7:0] = v[7:0];
    wr(rtc_pkg::OFS_CTRL, 32'h14);
  endtask : grab
  task t_capture;
    wr(rtc_pkg::OFS_CLK, 32'h01);
    wr(rtc_pkg::OFS_CTRL, 32'h14);
    grab();
    u = w;
    grab();
    chk({16'h0, w - u}, 32'h50);
    wr(rtc_pkg::OFS_CLK, 32'h00);
    grab();
    u = w;
    grab();
    chk({31'h0, (w - u) >= 16'h6 && (w - u) <= 16'h7}, 32'h1);
  endtask : t_capture
  task t_again;
    hresetn <= 1'b0;
    cyc(2);
    hresetn <= 1'b1;
    cyc(1);
    rd(rtc_pkg::OFS_CTRL, 32'h0);
    rd(rtc_pkg::OFS_RLD_LO, 32'h0);
    rd(rtc_pkg::OFS_CNT_HI, 32'h0);
  endtask : t_again
  initial begin
    cyc(5);
    hresetn <= 1'b1;
    cyc(1);
    t_reset();
    t_wide();
    t_split();
    t_rate(32'h04, 120, 10, 11, 0, 0);
    t_rate(32'h05, 800, 10, 11, 0, 0);
    t_rate(32'h0D, 800, 10, 11, 10, 11);
    t_capture();
    t_again();
    give_verdict();
  end
endmodule : tb_rtc_timer
